// ### hw/tmr16_core.sv
// 16-bit timer core: normal, clear-on-compare and fast pwm waveform modes
//
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module tmr16_core (
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  // register port
  input  wire logic [3:0]            reg_addr,
  input  wire logic [15:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [15:0]           reg_rdata,
  // interrupt acknowledges from the interrupt controller
  input  wire logic                  overflow_ack,
  input  wire logic                  compare_a_ack,
  input  wire logic                  compare_b_ack,
  input  wire logic                  capture_ack,
  // flags
  output logic                       overflow_flag,
  output logic                       compare_a_flag,
  output logic                       compare_b_flag,
  output logic                       capture_flag,
  // compare output pins
  output logic      [1:0]            wave_output,
  output logic      [1:0]            wave_output_oe
);
  import tmr16_pkg::*;

  logic [15:0] ctrl_ff;
  logic [15:0] count_value_ff;
  logic [15:0] cmp_buf_ff [2];
  logic [15:0] cmp_act_ff [2];
  logic [15:0] capture_value_ff;
  logic [3:0]  flags_ff;
  logic [1:0]  wave_ff;
  logic [9:0]  pre_ff;
  logic        block_ff;
  logic [15:0] rdata_ff;
  logic [1:0]  pin_ff;
  logic [1:0]  pin_oe_ff;

  logic [3:0]  wave_mode_select;
  logic [2:0]  clk_select;
  logic [1:0]  compare_output_mode [2];
  logic [1:0]  pin_direction;
  logic        tick;
  logic        is_pwm;
  logic        is_ctc;
  logic        fixed_top;
  logic [15:0] top_value;
  logic [15:0] top_mask;
  logic        at_top;
  logic [1:0]  hit;
  logic        ovf_evt;
  logic        wr_ctrl;
  logic        wr_count;
  logic        wr_capt;
  logic        wr_flags;
  logic [1:0]  wr_cmp;
  logic [9:0]  pre_mask;
  logic [3:0]  flag_set;
  logic [3:0]  flag_clr;

  // field decode; output modes never reach the counting path
  assign wave_mode_select       = ctrl_ff[CTRL_MODE_LSB +: 4];
  assign clk_select             = ctrl_ff[CTRL_CS_LSB +: 3];
  assign compare_output_mode[0] = ctrl_ff[CTRL_COMA_LSB +: 2];
  assign compare_output_mode[1] = ctrl_ff[CTRL_COMB_LSB +: 2];
  assign pin_direction          = {ctrl_ff[CTRL_DIRB_BIT], ctrl_ff[CTRL_DIRA_BIT]};

  // write strobes per register
  assign wr_ctrl  = reg_wr && (reg_addr == REG_CTRL);
  assign wr_count = reg_wr && (reg_addr == REG_COUNT);
  assign wr_capt  = reg_wr && (reg_addr == REG_CAPT);
  assign wr_flags = reg_wr && (reg_addr == REG_FLAGS);
  assign wr_cmp   = {reg_wr && (reg_addr == REG_CMP_B), reg_wr && (reg_addr == REG_CMP_A)};

  // prescaler select; codes 6 and 7 (external clock) are left stopped
  always_comb begin
    unique case (clk_select)
      3'h1:    pre_mask = PRE_DIV1;
      3'h2:    pre_mask = PRE_DIV8;
      3'h3:    pre_mask = PRE_DIV64;
      3'h4:    pre_mask = PRE_DIV256;
      3'h5:    pre_mask = PRE_DIV1024;
      default: pre_mask = PRE_DIV1;
    endcase
  end

  // free-running divider shared by all prescale taps
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pre_ff <= 10'h000;
    end else begin
      pre_ff <= pre_ff + 10'h001;
    end
  end

  assign tick = (clk_select != 3'h0) && (clk_select < 3'h6)
                && ((pre_ff & pre_mask) == pre_mask);

  // top selection per wave mode; unlisted modes count like mode zero
  always_comb begin
    is_pwm    = 1'b0;
    is_ctc    = 1'b0;
    fixed_top = 1'b0;
    top_value = CNT_MAX;
    unique case (wave_mode_select)
      MODE_CTC_A: begin
        is_ctc    = 1'b1;
        top_value = cmp_act_ff[0];
      end
      MODE_CTC_C: begin
        is_ctc    = 1'b1;
        top_value = capture_value_ff;
      end
      MODE_PWM8: begin
        is_pwm    = 1'b1;
        fixed_top = 1'b1;
        top_value = TOP_8BIT;
      end
      MODE_PWM9: begin
        is_pwm    = 1'b1;
        fixed_top = 1'b1;
        top_value = TOP_9BIT;
      end
      MODE_PWM10: begin
        is_pwm    = 1'b1;
        fixed_top = 1'b1;
        top_value = TOP_10BIT;
      end
      MODE_PWM_C: begin
        is_pwm    = 1'b1;
        top_value = capture_value_ff;
      end
      MODE_PWM_A: begin
        is_pwm    = 1'b1;
        top_value = cmp_act_ff[0];
      end
      default: top_value = CNT_MAX;
    endcase
  end

  assign top_mask = fixed_top ? top_value : CNT_MAX;

  // a count write blocks matches, the top match included, for one tick
  assign at_top  = (is_pwm || is_ctc) && (count_value_ff == top_value) && !block_ff;
  assign ovf_evt = is_pwm ? at_top : (count_value_ff == CNT_MAX);

  // match detect per compare channel
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_cmp
      assign hit[ch] = tick && !block_ff && (count_value_ff == cmp_act_ff[ch]);

      // buffer holds software value; active copy follows at top in pwm modes
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          cmp_buf_ff[ch] <= RST_WORD;
        end else if (wr_cmp[ch]) begin
          cmp_buf_ff[ch] <= reg_wdata & top_mask;
        end
      end

      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          cmp_act_ff[ch] <= RST_WORD;
        end else if (is_pwm) begin
          if (tick && at_top) begin
            cmp_act_ff[ch] <= cmp_buf_ff[ch];
          end
        end else if (wr_cmp[ch]) begin
          cmp_act_ff[ch] <= reg_wdata & top_mask;
        end
      end

      // output state: in fast pwm the bottom action wins over a match at top,
      // which is what makes compare equal to top a constant level
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          wave_ff[ch] <= 1'b0;
        end else if (is_pwm) begin
          if (tick && at_top && compare_output_mode[ch][1]) begin
            wave_ff[ch] <= !compare_output_mode[ch][0];
          end else if (hit[ch]) begin
            unique case (compare_output_mode[ch])
              COM_TOGGLE: wave_ff[ch] <= (ch == 0) ? !wave_ff[ch] : wave_ff[ch];
              COM_CLEAR:  wave_ff[ch] <= 1'b0;
              COM_SET:    wave_ff[ch] <= 1'b1;
              COM_OFF:    wave_ff[ch] <= wave_ff[ch];
            endcase
          end
        end else if (hit[ch]) begin
          unique case (compare_output_mode[ch])
            COM_TOGGLE: wave_ff[ch] <= !wave_ff[ch];
            COM_CLEAR:  wave_ff[ch] <= 1'b0;
            COM_SET:    wave_ff[ch] <= 1'b1;
            COM_OFF:    wave_ff[ch] <= wave_ff[ch];
          endcase
        end
      end

      // pin follows the output state only while direction is output
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          pin_ff[ch]    <= 1'b0;
          pin_oe_ff[ch] <= 1'b0;
        end else begin
          pin_ff[ch]    <= wave_ff[ch] && pin_direction[ch];
          pin_oe_ff[ch] <= pin_direction[ch] && (compare_output_mode[ch] != COM_OFF);
        end
      end
    end
  endgenerate

  // control register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= RST_WORD;
    end else if (wr_ctrl) begin
      ctrl_ff <= reg_wdata;
    end
  end

  // counter: software write wins over a tick; no tick means hold
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count_value_ff <= RST_WORD;
    end else if (wr_count) begin
      count_value_ff <= reg_wdata;
    end else if (tick) begin
      if (at_top) begin
        count_value_ff <= CNT_BOTTOM;
      end else begin
        count_value_ff <= count_value_ff + 16'h0001;
      end
    end
  end

  // match block stays armed until a tick has used it, even while stopped
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      block_ff <= 1'b0;
    end else if (wr_count) begin
      block_ff <= 1'b1;
    end else if (tick) begin
      block_ff <= 1'b0;
    end
  end

  // capture register, written only by software here
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      capture_value_ff <= RST_WORD;
    end else if (wr_capt) begin
      capture_value_ff <= reg_wdata;
    end
  end

  // flag events; the top event of a register top lands on its own flag
  always_comb begin
    flag_set           = 4'h0;
    flag_set[FLG_OVF]  = tick && ovf_evt;
    flag_set[FLG_CMPA] = hit[0]
                         || (tick && at_top && (top_value == cmp_act_ff[0])
                             && ((wave_mode_select == MODE_CTC_A)
                                 || (wave_mode_select == MODE_PWM_A)));
    flag_set[FLG_CMPB] = hit[1];
    flag_set[FLG_CAPT] = tick && at_top
                         && ((wave_mode_select == MODE_CTC_C)
                             || (wave_mode_select == MODE_PWM_C));
    flag_clr           = {capture_ack, compare_b_ack, compare_a_ack, overflow_ack};
    if (wr_flags) begin
      flag_clr = flag_clr | reg_wdata[3:0];
    end
  end

  // sticky flags; a set in the clearing cycle survives
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flags_ff <= 4'h0;
    end else begin
      flags_ff <= flag_set | (flags_ff & ~flag_clr);
    end
  end

  // read data stand one cycle after the strobe, zero otherwise
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= RST_WORD;
    end else if (reg_rd) begin
      unique case (reg_addr)
        REG_CTRL:  rdata_ff <= ctrl_ff;
        REG_COUNT: rdata_ff <= count_value_ff;
        REG_CMP_A: rdata_ff <= cmp_buf_ff[0];
        REG_CMP_B: rdata_ff <= cmp_buf_ff[1];
        REG_CAPT:  rdata_ff <= capture_value_ff;
        REG_FLAGS: rdata_ff <= {10'h000, wave_ff, flags_ff};
        default:   rdata_ff <= RST_WORD;
      endcase
    end else begin
      rdata_ff <= RST_WORD;
    end
  end

  assign reg_rdata      = rdata_ff;
  assign overflow_flag  = flags_ff[FLG_OVF];
  assign compare_a_flag = flags_ff[FLG_CMPA];
  assign compare_b_flag = flags_ff[FLG_CMPB];
  assign capture_flag   = flags_ff[FLG_CAPT];
  assign wave_output    = pin_ff;
  assign wave_output_oe = pin_oe_ff;

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  chk_normal_wrap: assert property (
    tick && !wr_count && (wave_mode_select == MODE_NORMAL) && (count_value_ff == CNT_MAX)
    |=> (count_value_ff == CNT_BOTTOM) && overflow_flag)
    else $error("normal mode wrap or overflow flag wrong");

  chk_count_hold: assert property (
    !tick && !wr_count |=> $stable(count_value_ff))
    else $error("count moved without a tick");

  chk_ctc_clear: assert property (
    tick && !wr_count && !block_ff && (wave_mode_select == MODE_CTC_A)
    && (count_value_ff == cmp_act_ff[0])
    |=> (count_value_ff == CNT_BOTTOM) && compare_a_flag)
    else $error("clear-on-compare did not clear or flag");

  chk_pwm_top: assert property (
    tick && !wr_count && is_pwm && at_top
    |=> (count_value_ff == CNT_BOTTOM) && overflow_flag)
    else $error("fast pwm top handling wrong");

  chk_buf_load: assert property (
    tick && is_pwm && at_top |=> cmp_act_ff[0] == $past(cmp_buf_ff[0]))
    else $error("compare buffer not loaded at top");

  chk_fixed_mask: assert property (
    wr_cmp[0] && (wave_mode_select == MODE_PWM8) |=> cmp_buf_ff[0][15:8] == 8'h00)
    else $error("upper compare bits not masked");

  chk_ctc_toggle: assert property (
    hit[0] && !is_pwm && (compare_output_mode[0] == COM_TOGGLE)
    |=> wave_ff[0] != $past(wave_ff[0]))
    else $error("output A did not toggle");

  chk_match_block: assert property (
    block_ff && tick && !compare_a_flag && !compare_b_flag && !capture_flag
    |=> !compare_a_flag && !compare_b_flag && !capture_flag)
    else $error("match seen while blocked");

  chk_com_off: assert property (
    (compare_output_mode[0] == COM_OFF) |=> $stable(wave_ff[0]))
    else $error("output state moved with output mode zero");

  chk_pin_gate: assert property (
    !pin_direction[0] |=> !wave_output_oe[0] && !wave_output[0])
    else $error("pin driven while direction is input");

  chk_ovf_ack: assert property (
    overflow_ack && !flag_set[FLG_OVF] |=> !overflow_flag)
    else $error("overflow flag not cleared by acknowledge");

  cov_ctc_clear: cover property (tick && is_ctc && at_top);
  cov_pwm_top: cover property (tick && is_pwm && at_top ##1 overflow_flag);
  cov_block: cover property (wr_count ##1 block_ff && tick);
endmodule : tmr16_core
`default_nettype wire

// ### hw/tmr16_pkg.sv
// constants, register map and mode codes of the 16-bit waveform timer
package tmr16_pkg;
  // register indices on the plain register port
  localparam logic [3:0]  REG_CTRL      = 4'h0;
  localparam logic [3:0]  REG_COUNT     = 4'h1;
  localparam logic [3:0]  REG_CMP_A     = 4'h2;
  localparam logic [3:0]  REG_CMP_B     = 4'h3;
  localparam logic [3:0]  REG_CAPT      = 4'h4;
  localparam logic [3:0]  REG_FLAGS     = 4'h5;
  // control field positions
  localparam int          CTRL_MODE_LSB = 0;
  localparam int          CTRL_CS_LSB   = 4;
  localparam int          CTRL_COMA_LSB = 8;
  localparam int          CTRL_COMB_LSB = 10;
  localparam int          CTRL_DIRA_BIT = 12;
  localparam int          CTRL_DIRB_BIT = 13;
  // flag positions
  localparam int          FLG_OVF       = 0;
  localparam int          FLG_CMPA      = 1;
  localparam int          FLG_CMPB      = 2;
  localparam int          FLG_CAPT      = 3;
  localparam int          FLG_WAVE_LSB  = 4;
  // reset values
  localparam logic [15:0] RST_WORD      = 16'h0000;
  // wave mode codes handled here
  localparam logic [3:0]  MODE_NORMAL   = 4'h0;
  localparam logic [3:0]  MODE_CTC_A    = 4'h4;
  localparam logic [3:0]  MODE_PWM8     = 4'h5;
  localparam logic [3:0]  MODE_PWM9     = 4'h6;
  localparam logic [3:0]  MODE_PWM10    = 4'h7;
  localparam logic [3:0]  MODE_CTC_C    = 4'hC;
  localparam logic [3:0]  MODE_PWM_C    = 4'hE;
  localparam logic [3:0]  MODE_PWM_A    = 4'hF;
  // fixed tops and maximum
  localparam logic [15:0] TOP_8BIT      = 16'h00FF;
  localparam logic [15:0] TOP_9BIT      = 16'h01FF;
  localparam logic [15:0] TOP_10BIT     = 16'h03FF;
  localparam logic [15:0] CNT_MAX       = 16'hFFFF;
  localparam logic [15:0] CNT_BOTTOM    = 16'h0000;
  // prescaler masks: tick when low bits of the free divider are all ones
  localparam logic [9:0]  PRE_DIV1      = 10'h000;
  localparam logic [9:0]  PRE_DIV8      = 10'h007;
  localparam logic [9:0]  PRE_DIV64     = 10'h03F;
  localparam logic [9:0]  PRE_DIV256    = 10'h0FF;
  localparam logic [9:0]  PRE_DIV1024   = 10'h3FF;
  // compare output modes
  localparam logic [1:0]  COM_OFF       = 2'h0;
  localparam logic [1:0]  COM_TOGGLE    = 2'h1;
  localparam logic [1:0]  COM_CLEAR     = 2'h2;
  localparam logic [1:0]  COM_SET       = 2'h3;
endpackage : tmr16_pkg

// ### testbench/tb.sv
// self-checking bench for the 16-bit waveform timer core
`timescale 1ns/1ns
`default_nettype none
module tb;
  import tmr16_pkg::*;
  typedef struct {
    string       name;
    logic [15:0] exp;
  } tmr16_note_t;

  // clock, reset and register port
  logic        mclk;
  logic        rst_n;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  // acknowledges and flags
  logic        overflow_ack;
  logic        compare_a_ack;
  logic        compare_b_ack;
  logic        capture_ack;
  logic        overflow_flag;
  logic        compare_a_flag;
  logic        compare_b_flag;
  logic        capture_flag;
  // pins
  logic [1:0]  wave_output;
  logic [1:0]  wave_output_oe;
  // bench state
  tmr16_note_t notes[$];
  tmr16_note_t note_cur;
  logic        rd_seen;
  logic [15:0] ctl_q;
  logic [31:0] rv;
  logic [1:0]  com;
  logic        bot;
  int          miscompares;
  int          checks_done;
  int          cyc;
  int          divs[5] = '{1, 8, 64, 256, 1024};

  tmr16_core u_tmr16_core (
    .mclk           (mclk),
    .rst_n          (rst_n),
    .reg_addr       (reg_addr),
    .reg_wdata      (reg_wdata),
    .reg_wr         (reg_wr),
    .reg_rd         (reg_rd),
    .reg_rdata      (reg_rdata),
    .overflow_ack   (overflow_ack),
    .compare_a_ack  (compare_a_ack),
    .compare_b_ack  (compare_b_ack),
    .capture_ack    (capture_ack),
    .overflow_flag  (overflow_flag),
    .compare_a_flag (compare_a_flag),
    .compare_b_flag (compare_b_flag),
    .capture_flag   (capture_flag),
    .wave_output    (wave_output),
    .wave_output_oe (wave_output_oe)
  );

  // free running clock, 10 ns period
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  // read data stands only in the cycle after the strobe, so look mid-cycle there
  always @(posedge mclk) rd_seen <= reg_rd;
  always @(negedge mclk) begin
    if (rd_seen === 1'b1) begin
      note_cur = notes.pop_front();
      check(note_cur.name, reg_rdata, note_cur.exp);
    end
  end

  // hang guard: far above the few thousand cycles the sequence needs
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  // each access leaves one idle cycle so no strobe is assigned twice in a step
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
    @(posedge mclk);
  endtask : wr

  task automatic rd(input string name, input logic [3:0] a, input logic [15:0] e);
    notes.push_back('{name, e});
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    @(posedge mclk);
  endtask : rd

  task automatic ack(input logic [3:0] m);
    {capture_ack, compare_b_ack, compare_a_ack, overflow_ack} <= m;
    @(posedge mclk);
    {capture_ack, compare_b_ack, compare_a_ack, overflow_ack} <= 4'h0;
    @(posedge mclk);
  endtask : ack

  // control word with the clock stopped: mode, output mode a, direction a
  task automatic setc(input logic [3:0] m, input logic [1:0] c, input logic dir);
    ctl_q = {3'b000, dir, 2'b00, c, 4'h0, m};
    wr(REG_CTRL, ctl_q);
  endtask : setc

  // start the clock, then stop it so that exactly n timer ticks land at divide by one
  task automatic run(input int n, input logic [2:0] cs);
    wr(REG_CTRL, ctl_q | {9'h000, cs, 4'h0});
    repeat (n - 2) @(posedge mclk);
    wr(REG_CTRL, ctl_q);
  endtask : run

  // outputs are looked at mid-cycle, then stimulus goes back to the rising edge
  task automatic pins(input logic [1:0] v, input logic [1:0] oe);
    @(negedge mclk);
    check("pins", {12'h000, wave_output_oe, wave_output}, {12'h000, oe, v});
    @(posedge mclk);
  endtask : pins

  task automatic flgs(input logic [3:0] e);
    @(negedge mclk);
    check("flag pins", {12'h000, capture_flag, compare_b_flag, compare_a_flag, overflow_flag},
          {12'h000, e});
    @(posedge mclk);
  endtask : flgs

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask : done

  // main sequence
  initial begin
    rst_n         = 1'b0;
    reg_addr      = 4'h0;
    reg_wdata     = 16'h0000;
    reg_wr        = 1'b0;
    reg_rd        = 1'b0;
    overflow_ack  = 1'b0;
    compare_a_ack = 1'b0;
    compare_b_ack = 1'b0;
    capture_ack   = 1'b0;
    ctl_q         = 16'h0000;
    miscompares   = 0;
    checks_done   = 0;
    cyc           = 0;
    rv            = $urandom(32'hCBA2);
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    rd("flags rst", REG_FLAGS, 16'h0000);
    pins(2'b00, 2'b00);
    wr(4'hA, 16'hFFFF);
    rd("unmapped", 4'hA, 16'h0000);
    done("reset");
    setc(MODE_NORMAL, COM_OFF, 1'b0);
    wr(REG_CMP_A, 16'h1234);
    wr(REG_CMP_B, 16'h0000);
    rv = $urandom();
    wr(REG_COUNT, rv[15:0]);
    rd("count rw", REG_COUNT, rv[15:0]);
    wr(REG_COUNT, 16'hFFFD);
    run(5, 3'h1);
    rd("count wrap", REG_COUNT, 16'h0002);
    rd("flags ovf", REG_FLAGS, 16'h0005);
    flgs(4'h5);
    ack(4'h5);
    rd("flags ack", REG_FLAGS, 16'h0000);
    wr(REG_CMP_B, 16'h1234);
    done("normal");
    setc(MODE_CTC_A, COM_TOGGLE, 1'b1);
    wr(REG_CMP_A, 16'h0003);
    wr(REG_COUNT, 16'h0000);
    run(5, 3'h1);
    rd("ctc count", REG_COUNT, 16'h0001);
    rd("ctc flags", REG_FLAGS, 16'h0012);
    pins(2'b01, 2'b01);
    ack(4'h2);
    setc(MODE_CTC_A, COM_TOGGLE, 1'b0);
    pins(2'b00, 2'b00);
    wr(REG_COUNT, 16'h0003);
    run(2, 3'h1);
    rd("blocked count", REG_COUNT, 16'h0005);
    rd("blocked flags", REG_FLAGS, 16'h0010);
    wr(REG_COUNT, 16'hFFFE);
    run(3, 3'h1);
    rd("ctc ovf", REG_FLAGS, 16'h0011);
    wr(REG_FLAGS, 16'h000F);
    done("ctc compare a");
    setc(MODE_CTC_C, COM_OFF, 1'b1);
    wr(REG_CAPT, 16'h0002);
    wr(REG_CMP_A, 16'h0001);
    wr(REG_COUNT, 16'h0000);
    run(4, 3'h1);
    rd("capt count", REG_COUNT, 16'h0001);
    rd("capt flags", REG_FLAGS, 16'h001A);
    flgs(4'hA);
    pins(2'b01, 2'b00);
    ack(4'hA);
    done("ctc capture");
    // inverting pass first: bottom clears a state left high above
    for (int i = 0; i < 2; i++) begin
      com = (i == 0) ? COM_SET : COM_CLEAR;
      bot = (i == 0) ? 1'b0 : 1'b1;
      setc(MODE_PWM8, com, 1'b1);
      wr(REG_CMP_A, 16'hFF80);
      rd("masked cmp", REG_CMP_A, 16'h0080);
      wr(REG_FLAGS, 16'h000F);
      wr(REG_COUNT, 16'h00FE);
      run(3, 3'h1);
      rd("pwm top", REG_COUNT, 16'h0001);
      rd("pwm bottom", REG_FLAGS, {11'h000, bot, 4'h1});
      wr(REG_FLAGS, 16'h000F);
      wr(REG_COUNT, 16'h007E);
      run(4, 3'h1);
      rd("pwm match", REG_FLAGS, {11'h000, ~bot, 4'h2});
      pins({1'b0, ~bot}, 2'b01);
    end
    // the wider fixed tops: mask on write and clear after top
    for (int i = 0; i < 2; i++) begin
      setc((i == 0) ? MODE_PWM9 : MODE_PWM10, COM_OFF, 1'b0);
      wr(REG_CMP_A, 16'hFFFF);
      rd("wide mask", REG_CMP_A, (i == 0) ? TOP_9BIT : TOP_10BIT);
      wr(REG_FLAGS, 16'h000F);
      wr(REG_COUNT, ((i == 0) ? TOP_9BIT : TOP_10BIT) - 16'h0001);
      run(3, 3'h1);
      rd("wide top", REG_COUNT, 16'h0001);
    end
    done("fast pwm fixed top");
    setc(MODE_CTC_A, COM_OFF, 1'b0);
    wr(REG_CMP_A, 16'h0005);
    setc(MODE_PWM_A, COM_OFF, 1'b0);
    wr(REG_CMP_A, 16'h0008);
    wr(REG_FLAGS, 16'h000F);
    wr(REG_COUNT, 16'h0000);
    run(7, 3'h1);
    rd("buffered top", REG_COUNT, 16'h0001);
    rd("buffered flags", REG_FLAGS, 16'h0003);
    rd("cmp buffer", REG_CMP_A, 16'h0008);
    done("fast pwm compare top");
    setc(MODE_PWM_C, COM_OFF, 1'b0);
    wr(REG_CAPT, 16'h0003);
    wr(REG_FLAGS, 16'h000F);
    wr(REG_COUNT, 16'h0005);
    run(3, 3'h1);
    rd("missed top", REG_COUNT, 16'h0008);
    rd("missed flags", REG_FLAGS, 16'h0000);
    done("fast pwm capture top");
    // toggle at a compare top, then at the smallest register top
    setc(MODE_PWM_A, COM_TOGGLE, 1'b1);
    wr(REG_CMP_A, 16'h0003);
    wr(REG_FLAGS, 16'h000F);
    wr(REG_COUNT, 16'h0007);
    run(2, 3'h1);
    rd("toggle top", REG_FLAGS, 16'h0013);
    wr(REG_FLAGS, 16'h000F);
    run(4, 3'h1);
    rd("toggle min top", REG_COUNT, 16'h0000);
    rd("toggle back", REG_FLAGS, 16'h0003);
    done("fast pwm toggle");
    // compare equal to top: the bottom action must beat the match
    setc(MODE_PWM8, COM_CLEAR, 1'b1);
    wr(REG_CMP_A, 16'h00FF);
    wr(REG_FLAGS, 16'h000F);
    for (int i = 0; i < 2; i++) begin
      wr(REG_COUNT, 16'h00FE);
      run(2, 3'h1);
    end
    rd("level at top", REG_FLAGS, 16'h0013);
    // reset in mid-run while the output state is high
    rst_n <= 1'b0;
    @(posedge mclk);
    rst_n <= 1'b1;
    rd("wave reset", REG_FLAGS, 16'h0000);
    done("fast pwm level and reset");
    // a window of twice the divisor holds exactly two ticks at any divider phase
    setc(MODE_NORMAL, COM_OFF, 1'b0);
    for (int i = 0; i < 5; i++) begin
      wr(REG_COUNT, 16'h0000);
      run(2 * divs[i], 3'(i + 1));
      rd("prescaled", REG_COUNT, 16'h0002);
    end
    done("prescaler");
    @(posedge mclk);
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
